// [hw/byte_timer.sv]
// byte timer: counter, capture, compare and AXI4-Lite registers
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module byte_timer
	import byte_timer_pkg::*;
#(
	parameter int OSC_DIV     = byte_timer_pkg::OSC_DIV_DEF,
	parameter bit CAP1_BONDED = 1'b1,
	parameter bit CAP2_BONDED = 1'b1
)(
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// oscillator half-rate tick, same clock domain
	input  wire logic        osc_tick,
	// timer pins
	input  wire logic        capture_in_one,
	input  wire logic        capture_in_two,
	output logic             compare_out_one,
	output logic             compare_out_one_oe,
	output logic             compare_out_two,
	output logic             compare_out_two_oe,
	// interrupt request
	output logic             timer_irq,
	// AXI4-Lite write address and data
	input  wire logic [byte_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [byte_timer_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import byte_timer_pkg::*;

	// software registers
	logic [7:0]        ctrl1_ff;
	logic [7:0]        ctrl2_ff;
	logic [7:0]        sys_ff;
	logic [7:0]        cmp_ff [2];
	// counter and flags
	logic [7:0]        count_ff;
	logic              ovf_flag_ff;
	logic              ovf_armed_ff;
	logic [1:0]        cap_flag_ff;
	logic [1:0]        cap_armed_ff;
	logic [1:0]        cmp_flag_ff;
	logic [1:0]        cmp_armed_ff;
	logic [1:0]        pin_ff;
	// bus holding registers
	logic              aw_held_ff;
	logic              w_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [7:0]        wdata_ff;
	logic              wbyte_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	// decoded strobes
	logic              wr_go;
	logic              rd_go;
	logic              wr_hit;
	logic              rd_hit;
	logic [7:0]        nxt_rdata;
	logic              tick;
	logic              cnt_write;
	logic              mode_special;
	logic              fast_sel;
	logic              ovf_event;
	logic              st_read;
	logic              main_read;
	logic [1:0]        cap_event;
	logic [1:0]        cap_access;
	logic [1:0]        cmp_event;
	logic [1:0]        cmp_access;
	logic [1:0]        lvl;
	logic [1:0]        pin_en;
	logic [7:0]        cap_value [2];
	clk_sel_t          clk_sel;

	capture_if cap_bus [2] ();

	// handshake: one read in flight at most; a second write can be taken and held while a write response waits
	assign s_axi_awready = ce && !aw_held_ff;
	assign s_axi_wready  = ce && !w_held_ff;
	assign s_axi_arready = ce && !rvalid_ff;
	assign wr_go = ce && aw_held_ff && w_held_ff && !bvalid_ff;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// address, data and response of the write channel
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= 8'h00;
			wbyte_ff   <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held_ff <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata[7:0];
				wbyte_ff  <= s_axi_wstrb[0];
			end
			else if (wr_go)
				w_held_ff <= 1'b0;
			if (wr_go)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// write address decode
	always_comb
	begin
		case (awaddr_ff)
			OFF_CTRL1, OFF_CTRL2, OFF_STATUS, OFF_MAINCNT,
			OFF_ALTCNT, OFF_CAP1, OFF_CAP2, OFF_CMP1, OFF_CMP2,
			OFF_SYS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// read data mux; status bits show live flags
	always_comb
	begin
		rd_hit    = 1'b1;
		nxt_rdata = 8'h00;
		case (s_axi_araddr)
			OFF_CTRL1:   nxt_rdata = ctrl1_ff;
			OFF_CTRL2:   nxt_rdata = ctrl2_ff;
			OFF_STATUS:
			begin
				nxt_rdata[ST_CAPF1] = cap_flag_ff[0];
				nxt_rdata[ST_CMPF1] = cmp_flag_ff[0];
				nxt_rdata[ST_OVF]   = ovf_flag_ff;
				nxt_rdata[ST_CAPF2] = cap_flag_ff[1];
				nxt_rdata[ST_CMPF2] = cmp_flag_ff[1];
			end
			OFF_MAINCNT: nxt_rdata = count_ff;
			OFF_ALTCNT:  nxt_rdata = count_ff;
			OFF_CAP1:    nxt_rdata = cap_value[0];
			OFF_CAP2:    nxt_rdata = cap_value[1];
			OFF_CMP1:    nxt_rdata = cmp_ff[0];
			OFF_CMP2:    nxt_rdata = cmp_ff[1];
			OFF_SYS:     nxt_rdata = sys_ff;
			default:     rd_hit = 1'b0;
		endcase
	end

	// read answer registered one cycle after address
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (rd_go)
			begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= {24'h0, nxt_rdata};
				rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	// control and system registers; low byte lane only
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl1_ff <= 8'h00;
			ctrl2_ff <= 8'h00;
			sys_ff   <= SYS_RESET;
		end
		else if (wr_go && wbyte_ff)
		begin
			if (awaddr_ff == OFF_CTRL1)
				ctrl1_ff <= wdata_ff;
			if (awaddr_ff == OFF_CTRL2)
				ctrl2_ff <= wdata_ff;
			if (awaddr_ff == OFF_SYS)
				sys_ff <= wdata_ff;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmp_ff[0] <= CMP_RESET;
			cmp_ff[1] <= CMP_RESET;
		end
		else if (wr_go && wbyte_ff)
		begin
			if (awaddr_ff == OFF_CMP1)
				cmp_ff[0] <= wdata_ff;
			if (awaddr_ff == OFF_CMP2)
				cmp_ff[1] <= wdata_ff;
		end
	end

	assign cnt_write = wr_go && (awaddr_ff == OFF_MAINCNT
		|| awaddr_ff == OFF_ALTCNT);
	assign clk_sel = clk_sel_t'(ctrl2_ff[C2_CLK_LO +: 2]);
	assign fast_sel = (clk_sel == SEL_DIV2);
	assign mode_special = ctrl2_ff[C2_OPM] || ctrl2_ff[C2_PWM];

	timer_prescaler #(
		.OSC_DIV (OSC_DIV)
	) u_prescaler (
		.clk      (clk),
		.resetn   (resetn),
		.ce       (ce),
		.run      (!sys_ff[SYS_HALT]),
		.restart  (cnt_write),
		.sel      (clk_sel),
		.osc_tick (osc_tick),
		.tick     (tick)
	);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			count_ff <= CNT_RESET;
		else if (ce && cnt_write)
			count_ff <= CNT_RESET;
		else if (ce && tick)
			count_ff <= count_ff + CNT_ONE;
	end

	// side effects of reads and accesses
	assign st_read   = rd_go && s_axi_araddr == OFF_STATUS;
	assign main_read = rd_go && s_axi_araddr == OFF_MAINCNT;
	assign ovf_event = ce && tick && count_ff == CNT_TOP;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ovf_flag_ff  <= 1'b0;
			ovf_armed_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (ovf_event)
				ovf_flag_ff <= 1'b1;
			else if (main_read && ovf_armed_ff)
				ovf_flag_ff <= 1'b0;
			if (main_read || !ovf_flag_ff)
				ovf_armed_ff <= 1'b0;
			else if (st_read)
				ovf_armed_ff <= 1'b1;
		end
	end

	// per-channel capture and compare logic
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			localparam logic [5:0] CAP_OFF = gi ? OFF_CAP2 : OFF_CAP1;
			localparam logic [5:0] CMP_OFF = gi ? OFF_CMP2 : OFF_CMP1;

			// capture one idle in special modes
			assign cap_bus[gi].allow = (gi == 1) || !mode_special;
			assign cap_bus[gi].edge_sel = gi ? ctrl2_ff[C2_EDGE2]
				: ctrl1_ff[C1_EDGE1];
			assign cap_bus[gi].count = count_ff;
			assign cap_event[gi] = cap_bus[gi].event_pulse;
			assign cap_value[gi] = cap_bus[gi].value;

			assign cap_access[gi] = (rd_go && s_axi_araddr == CAP_OFF)
				|| (wr_go && awaddr_ff == CAP_OFF);
			assign cmp_access[gi] = (rd_go && s_axi_araddr == CMP_OFF)
				|| (wr_go && awaddr_ff == CMP_OFF);

			// plus one at div2, equal otherwise
			assign cmp_event[gi] = ce && tick && (fast_sel
				? (count_ff + CNT_ONE) == cmp_ff[gi]
				: count_ff == cmp_ff[gi]);

			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					cap_flag_ff[gi]  <= 1'b0;
					cap_armed_ff[gi] <= 1'b0;
				end
				else if (ce)
				begin
					if (cap_event[gi])
						cap_flag_ff[gi] <= 1'b1;
					else if (cap_access[gi] && cap_armed_ff[gi])
						cap_flag_ff[gi] <= 1'b0;
					if (cap_access[gi] || !cap_flag_ff[gi])
						cap_armed_ff[gi] <= 1'b0;
					else if (st_read)
						cap_armed_ff[gi] <= 1'b1;
				end
			end

			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
				begin
					cmp_flag_ff[gi]  <= 1'b0;
					cmp_armed_ff[gi] <= 1'b0;
				end
				else if (ce)
				begin
					if (cmp_event[gi])
						cmp_flag_ff[gi] <= 1'b1;
					else if (cmp_access[gi] && cmp_armed_ff[gi])
						cmp_flag_ff[gi] <= 1'b0;
					if (cmp_access[gi] || !cmp_flag_ff[gi])
						cmp_armed_ff[gi] <= 1'b0;
					else if (st_read)
						cmp_armed_ff[gi] <= 1'b1;
				end
			end

			assign lvl[gi] = gi ? ctrl1_ff[C1_LVL2] : ctrl1_ff[C1_LVL1];
			assign pin_en[gi] = gi ? ctrl2_ff[C2_PIN2] : ctrl2_ff[C2_PIN1];

			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					pin_ff[gi] <= 1'b0;
				else if (cmp_event[gi] && pin_en[gi])
					pin_ff[gi] <= lvl[gi];
			end
		end
	endgenerate

	capture_channel #(
		.BONDED (CAP1_BONDED)
	) u_cap_one (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.pin    (capture_in_one),
		.cif    (cap_bus[0])
	);

	capture_channel #(
		.BONDED (CAP2_BONDED)
	) u_cap_two (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.pin    (capture_in_two),
		.cif    (cap_bus[1])
	);

	// pins driven only while enabled
	assign compare_out_one    = pin_ff[0];
	assign compare_out_two    = pin_ff[1];
	assign compare_out_one_oe = pin_en[0];
	assign compare_out_two_oe = pin_en[1];

	assign timer_irq = !sys_ff[SYS_MASK] && (
		(ovf_flag_ff && ctrl1_ff[C1_OVF_IE])
		|| (|cap_flag_ff && ctrl1_ff[C1_CAP_IE])
		|| (|cmp_flag_ff && ctrl1_ff[C1_CMP_IE]));
endmodule

// [hw/byte_timer_pkg.sv]
// constants, register map and field layout of the byte timer
// Behaviour
// - prescaler divides cpu clock 2/4/8, oscillator 8000
// - 8-bit up-counter seen through two count registers
// - alternate count read leaves overflow flag set
// - writing either count register reloads FCh
// - counter resets to FCh in every mode
// - count sequence period follows clock select field
// - rollover FFh to 00h sets overflow flag
// - overflow interrupt needs enable and clear cpu mask
// - runs in wait, frozen in halt
// - two capture registers latch count on edge
// - capture registers are read-only
// - capture edge sets flag, keeps latest count
// - one shared enable for both capture interrupts
// - capture flag clears: status read, capture access
// - one pulse or pwm mode: only capture two
// - bonded capture inputs always connected, only selected edge counts
// - unbonded timer input always reads one
// - compare match sets flag, drives pin, interrupts
// - both compare registers checked every timer tick
// - compare registers software-only, reset to 00h
// - matched pin takes programmed level, resets low
// - compare flag clears: status read, compare access
// - divide-by-2 matches at plus one, slower at equal
package byte_timer_pkg;
	localparam int          ADDR_W      = 6;
	localparam logic [7:0]  CNT_RESET   = 8'hfc;
	localparam logic [7:0]  CNT_TOP     = 8'hff;
	localparam logic [7:0]  CMP_RESET   = 8'h00;
	localparam logic [7:0]  CNT_ONE     = 8'h01;
	localparam int          OSC_DIV_DEF = 8000;
	// register byte offsets
	localparam logic [5:0]  OFF_CTRL1   = 6'h00;
	localparam logic [5:0]  OFF_CTRL2   = 6'h04;
	localparam logic [5:0]  OFF_STATUS  = 6'h08;
	localparam logic [5:0]  OFF_MAINCNT = 6'h0c;
	localparam logic [5:0]  OFF_ALTCNT  = 6'h10;
	localparam logic [5:0]  OFF_CAP1    = 6'h14;
	localparam logic [5:0]  OFF_CAP2    = 6'h18;
	localparam logic [5:0]  OFF_CMP1    = 6'h1c;
	localparam logic [5:0]  OFF_CMP2    = 6'h20;
	localparam logic [5:0]  OFF_SYS     = 6'h24;
	// timer_control_one fields
	localparam int          C1_CAP_IE   = 7;
	localparam int          C1_CMP_IE   = 6;
	localparam int          C1_OVF_IE   = 5;
	localparam int          C1_EDGE1    = 1;
	localparam int          C1_LVL1     = 0;
	localparam int          C1_LVL2     = 2;
	// timer_control_two fields
	localparam int          C2_PIN1     = 7;
	localparam int          C2_PIN2     = 6;
	localparam int          C2_OPM      = 5;
	localparam int          C2_PWM      = 4;
	localparam int          C2_CLK_LO   = 2;
	localparam int          C2_EDGE2    = 1;
	// timer_status_reg fields
	localparam int          ST_CAPF1    = 7;
	localparam int          ST_CMPF1    = 6;
	localparam int          ST_OVF      = 5;
	localparam int          ST_CAPF2    = 4;
	localparam int          ST_CMPF2    = 3;
	// system register fields
	localparam int          SYS_MASK    = 0;
	localparam int          SYS_HALT    = 1;
	localparam logic [7:0]  SYS_RESET   = 8'h01;
	// clock select codes and fast divider terminal counts
	typedef enum logic [1:0] {
		SEL_DIV2 = 2'h0,
		SEL_DIV4 = 2'h1,
		SEL_DIV8 = 2'h2,
		SEL_OSC  = 2'h3
	} clk_sel_t;
	localparam logic [2:0]  DIV2_LAST   = 3'h1;
	localparam logic [2:0]  DIV4_LAST   = 3'h3;
	localparam logic [2:0]  DIV8_LAST   = 3'h7;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// [hw/capture_channel.sv]
// one input capture channel: pin synchroniser, edge select, latch
`timescale 1ns/1ps
module capture_channel #(
	parameter bit BONDED = 1'b1
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	// pin and core side
	input  wire logic pin,
	capture_if.channel cif
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	logic level;
	logic rise;
	logic fall;
	logic [7:0] value_ff;

	// two-stage synchroniser for the asynchronous pin
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
		end
		else if (ce)
		begin
			meta_ff <= pin;
			sync_ff <= meta_ff;
			prev_ff <= level;
		end
	end

	assign level = BONDED ? sync_ff : 1'b1;
	assign rise  = level && !prev_ff;
	assign fall  = !level && prev_ff;
	assign cif.event_pulse = ce && cif.allow
		&& (cif.edge_sel ? rise : fall);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			value_ff <= 8'h00;
		else if (cif.event_pulse)
			value_ff <= cif.count;
	end
	assign cif.value = value_ff;
endmodule

// [hw/capture_if.sv]
// signals between the timer core and one capture channel
`timescale 1ns/1ps
interface capture_if;
	logic       edge_sel;
	logic       allow;
	logic [7:0] count;
	logic       event_pulse;
	logic [7:0] value;
	modport owner (output edge_sel, output allow, output count,
		input event_pulse, input value);
	modport channel (input edge_sel, input allow, input count,
		output event_pulse, output value);
endinterface

// [hw/timer_prescaler.sv]
// prescaler producing one-cycle timer ticks
`timescale 1ns/1ps
module timer_prescaler
	import byte_timer_pkg::*;
#(
	parameter int OSC_DIV = OSC_DIV_DEF
)(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               ce,
	// control
	input  wire logic               run,
	input  wire logic               restart,
	input  wire byte_timer_pkg::clk_sel_t sel,
	input  wire logic               osc_tick,
	// result
	output logic                    tick
);
	localparam logic [12:0] OSC_LAST = 13'(OSC_DIV - 1);
	logic [2:0]  fast_ff;
	logic [12:0] slow_ff;
	logic [2:0]  fast_last;
	logic        slow_hit;

	// terminal count of the cpu clock divider
	always_comb
	begin
		case (sel)
			SEL_DIV2: fast_last = DIV2_LAST;
			SEL_DIV4: fast_last = DIV4_LAST;
			default:  fast_last = DIV8_LAST;
		endcase
	end

	assign slow_hit = osc_tick && (slow_ff == OSC_LAST);
	assign tick = run && ((sel == SEL_OSC) ? slow_hit
		: (fast_ff == fast_last));

	// cpu clock divider; halt freezes it
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			fast_ff <= 3'h0;
		else if (ce && (restart || tick))
			fast_ff <= 3'h0;
		else if (ce && run && sel != SEL_OSC)
			fast_ff <= fast_ff + 3'h1;
	end

	// oscillator tick divider
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			slow_ff <= 13'h0;
		else if (ce && (restart || tick))
			slow_ff <= 13'h0;
		else if (ce && run && sel == SEL_OSC && osc_tick)
			slow_ff <= slow_ff + 13'h1;
	end
endmodule

// [tb/byte_timer_sva.sv]
// port assertions for the byte timer
`timescale 1ns/1ps
module byte_timer_sva
	import byte_timer_pkg::*;
(
	// clock, reset, enable
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ce,
	// pins and interrupt
	input wire logic        compare_out_one,
	input wire logic        compare_out_one_oe,
	input wire logic        compare_out_two,
	input wire logic        timer_irq,
	// bus handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [byte_timer_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// pins and request held low through reset
	property p_rst; disable iff (1'b0)
		!resetn |-> !(compare_out_one || compare_out_two || timer_irq);
	endproperty
	a_rst: assert property (p_rst) else $error("pin high in reset");
	// pin latch keeps its level while its driver is off
	property p_pin;
		!compare_out_one_oe && !$past(compare_out_one_oe)
		|-> $stable(compare_out_one);
	endproperty
	a_pin: assert property (p_pin) else $error("pin moved undriven");
	// disabled block offers no ready
	property p_ce; !ce |-> !s_axi_awready && !s_axi_arready; endproperty
	a_ce: assert property (p_ce) else $error("ready while disabled");
	// read answered one cycle after the address
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("late read answer");
	// unmapped read gives error and zero data
	property p_unmap;
		s_axi_arvalid && s_axi_arready && s_axi_araddr >= 6'h28
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("bad unmapped read");
	// no new address while data waits
	property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rblk: assert property (p_rblk) else $error("address taken early");
	// read and write answers drop after acceptance
	property p_rone; ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rone: assert property (p_rone) else $error("read answer repeated");
	property p_bone; ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bone: assert property (p_bone) else $error("write answer repeated");
endmodule

bind byte_timer byte_timer_sva chk_u (
	.clk, .resetn, .ce, .compare_out_one, .compare_out_one_oe,
	.compare_out_two, .timer_irq, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// [tb/byte_timer_test.sv]
// self-checking bench for the byte timer
`timescale 1ns/1ps
module byte_timer_test;
	import byte_timer_pkg::*;
	logic              clk, resetn, ce, osc_tick, timer_irq;
	logic              capture_in_one, capture_in_two;
	logic              compare_out_one, compare_out_one_oe;
	logic              compare_out_two, compare_out_two_oe;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic              s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	logic [7:0]        rd;
	int                mismatches = 0, comparisons = 0, cycles = 0;

	byte_timer #(.OSC_DIV(4)) dut_u (
		.clk, .resetn, .ce, .osc_tick, .capture_in_one, .capture_in_two,
		.compare_out_one, .compare_out_one_oe, .compare_out_two,
		.compare_out_two_oe, .timer_irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	timer_pins pins_u (.clk, .capture_in_one, .capture_in_two, .osc_tick);

	// clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		resetn <= 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
	endtask
	// bus write: address and data offered together
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// bus read into rd
	task automatic rdr(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rd = s_axi_rdata[7:0];
		s_axi_rready <= 1'b0;
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (timer_irq !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		check(timer_irq, 1'b1);
	endtask

	// reset values, reload, freeze and bus errors
	task automatic t_regs();
		rdr(OFF_CMP1);
		check(rd, CMP_RESET);
		rdr(OFF_SYS);
		check(rd, SYS_RESET);
		wr(OFF_CMP2, 8'ha5);
		rdr(OFF_CMP2);
		check(rd, 8'ha5);
		s_axi_wstrb <= 4'h0;
		wr(OFF_CMP2, 8'h5a);
		s_axi_wstrb <= 4'h1;
		rdr(OFF_CMP2);
		check(rd, 8'ha5);
		wr(OFF_SYS, 8'h03);
		wr(OFF_ALTCNT, 8'h37);
		rdr(OFF_MAINCNT);
		check(rd, CNT_RESET);
		ce <= 1'b0;
		repeat (8) @(posedge clk);
		ce <= 1'b1;
		rdr(OFF_ALTCNT);
		check(rd, CNT_RESET);
		rdr(6'h28);
		check(s_axi_rresp, RESP_SLVERR);
		wr(6'h2c, 8'h00);
		check(s_axi_bresp, RESP_SLVERR);
		$display("regs test done");
	endtask
	// overflow period per clock select, flag and mask handling
	task automatic t_period();
		int t1;
		int div;
		for (int s = 0; s < 4; s++)
		begin
			div = (s == 3) ? 4 * 3 : 2 << s;
			wr(OFF_SYS, 8'h03);
			wr(OFF_CTRL2, 8'(s << 2));
			wr(OFF_CTRL1, 8'h20);
			wr(OFF_MAINCNT, 8'h00);
			rdr(OFF_STATUS);
			rdr(OFF_MAINCNT);
			wr(OFF_SYS, 8'h00);
			wait_irq();
			t1 = cycles;
			rdr(OFF_ALTCNT);
			rdr(OFF_STATUS);
			check(rd[ST_OVF], 1'b1);
			rdr(OFF_MAINCNT);
			check(timer_irq, 1'b0);
			wait_irq();
			check(cycles - t1, 256 * div);
			wr(OFF_SYS, 8'h01);
			check(timer_irq, 1'b0);
			wr(OFF_SYS, 8'h00);
			check(timer_irq, 1'b1);
			rdr(OFF_STATUS);
			rdr(OFF_MAINCNT);
		end
		$display("period test done");
	endtask
	// capture edges, flags, read-only values, one pulse mode
	task automatic t_capture();
		wr(OFF_SYS, 8'h03);
		wr(OFF_MAINCNT, 8'h00);
		wr(OFF_CTRL1, 8'h82);
		pins_u.drive(1, 1'b0);
		pins_u.drive(2, 1'b0);
		repeat (6) @(posedge clk);
		rdr(OFF_STATUS);
		check(rd & 8'h90, 8'h10);
		pins_u.drive(1, 1'b1);
		repeat (6) @(posedge clk);
		wr(OFF_SYS, 8'h02);
		check(timer_irq, 1'b1);
		rdr(OFF_STATUS);
		check(rd & 8'h90, 8'h90);
		wr(OFF_CAP1, 8'h55);
		rdr(OFF_CAP1);
		check(rd, CNT_RESET);
		rdr(OFF_STATUS);
		check(rd & 8'h90, 8'h10);
		wr(OFF_CTRL2, 8'h20);
		pins_u.drive(1, 1'b0);
		pins_u.drive(1, 1'b1);
		repeat (6) @(posedge clk);
		rdr(OFF_STATUS);
		check(rd & 8'h90, 8'h10);
		wr(OFF_CTRL2, 8'h10);
		pins_u.drive(1, 1'b0);
		pins_u.drive(1, 1'b1);
		repeat (6) @(posedge clk);
		rdr(OFF_STATUS);
		check(rd & 8'h90, 8'h10);
		$display("capture test done");
	endtask
	// compare timing against overflow, pin drive, flag clear
	task automatic t_compare();
		int ti, t1, t2;
		for (int s = 0; s < 3; s += 2)
		begin
			do_reset();
			wr(OFF_SYS, 8'h03);
			wr(OFF_CTRL1, 8'h25);
			wr(OFF_CTRL2, 8'hc0 | 8'(s << 2));
			check(compare_out_one_oe, 1'b1);
			check(compare_out_two_oe, 1'b1);
			wr(OFF_MAINCNT, 8'h00);
			rdr(OFF_STATUS);
			rdr(OFF_MAINCNT);
			wr(OFF_CMP1, 8'h00);
			wr(OFF_CMP2, 8'h01);
			check(compare_out_one, 1'b0);
			wr(OFF_SYS, 8'h00);
			ti = -1;
			t1 = -1;
			t2 = -1;
			for (int n = 0; n < 400 && t2 < 0; n++)
			begin
				@(posedge clk);
				if (timer_irq === 1'b1 && ti < 0)
					ti = n;
				if (compare_out_one === 1'b1 && t1 < 0)
					t1 = n;
				if (compare_out_two === 1'b1)
					t2 = n;
			end
			check(t1 - ti, s * 4);
			check(t2 - ti, s * 7 + 2);
			rdr(OFF_STATUS);
			check(rd & 8'h48, 8'h48);
			wr(OFF_CMP1, 8'h00);
			rdr(OFF_STATUS);
			check(rd & 8'h48, 8'h08);
			wr(OFF_CTRL1, 8'h40);
			check(timer_irq, 1'b1);
		end
		$display("compare test done");
	endtask

	// main sequence
	initial
	begin
		resetn = 1'b1;
		ce = 1'b1;
		s_axi_wstrb = 4'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		do_reset();
		t_regs();
		t_period();
		t_capture();
		t_compare();
		print_verdict();
	end
endmodule

// [tb/timer_pins.sv]
// far side of the timer pins: capture drivers and oscillator ticks
`timescale 1ns/1ps
module timer_pins (
	// clock
	input  wire logic clk,
	// pins toward the timer
	output logic      capture_in_one,
	output logic      capture_in_two,
	output logic      osc_tick
);
	int div_ff = 0;
	// idle pins sit high
	initial
	begin
		capture_in_one = 1'b1;
		capture_in_two = 1'b1;
		osc_tick = 1'b0;
	end
	// oscillator tick, one cycle in three
	always @(posedge clk)
	begin
		div_ff <= (div_ff == 2) ? 0 : div_ff + 1;
		osc_tick <= (div_ff == 2);
	end
	// move one capture pin just after an edge
	task automatic drive(input int idx, input logic lvl);
		@(posedge clk);
		if (idx == 1)
			capture_in_one <= lvl;
		else
			capture_in_two <= lvl;
	endtask
endmodule
